/* plalu_defines.svh */
/*
 * Constants for the partial and linked load unit: data width, access types,
 * field positions and reset values.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef PLALU_DEFINES_SVH
`define PLALU_DEFINES_SVH

`define PLALU_XLEN        64
`define PLALU_DISP_MSB    15
`define PLALU_LANE_BITS   3
`define PLALU_TYPE_HALF   3'h1
`define PLALU_TYPE_WORD   3'h3
`define PLALU_TYPE_DBL    3'h7
`define PLALU_ZERO64      64'h0000000000000000
`define PLALU_ZERO3       3'h0

`endif

/* plalu_pkg.sv */
/*
 * Types for the partial and linked load unit.
 * Assumes plalu_defines.svh is on the include path.
 */
`include "plalu_defines.svh"
package plalu_pkg;

	// Load kinds handled here
	typedef enum logic [2:0]
	{
		PLALU_OP_NONE,
		PLALU_OP_RIGHT,
		PLALU_OP_LEFT,
		PLALU_OP_HALF_S,
		PLALU_OP_HALF_U,
		PLALU_OP_LINK_W,
		PLALU_OP_LINK_D
	} plalu_op_t;

	// Issue request from the pipeline
	typedef struct packed
	{
		plalu_op_t   op;
		logic [4:0]  target;
		logic [15:0] disp;
		logic [63:0] base;
		logic [63:0] target_old;
	} plalu_req_t;

	// Request to cache and memory
	typedef struct packed
	{
		logic [63:0] vaddr;
		logic [63:0] paddr;
		logic [2:0]  access_type;
	} plalu_mem_t;

	// Register file write-back
	typedef struct packed
	{
		logic [4:0]  target;
		logic [63:0] data;
	} plalu_wb_t;

endpackage

/* plalu_load_unit.sv */
/*
 * Partial and linked load unit: address formation, lane selection,
 * extension, alignment faults, bypass, link flag and ordering barrier.
 * Assumes the cache answers each request with mem_done, possibly later,
 * and that virtual to physical translation is identity.
 */
// Summary of operation
// - Right partial load address is sign-extended 16-bit displacement plus base.
// - Right partial load reads only within its aligned doubleword, one to eight bytes.
// - Addressed byte lands in low byte, upward; upper destination bytes kept.
// - Left and right partial loads combine to assemble eight unaligned bytes.
// - Pending target value is forwarded so back-to-back loads need no no-op.
// - Right partial load never raises an alignment fault.
// - Big-endian memory forces low three physical bits to zero for right load.
// - Byte lane is low three address bits XOR replicated processor endian flag.
// - Signed halfword load sign-extends the halfword to 64 bits.
// - Unsigned halfword load zero-fills above the halfword.
// - Halfword loads fault on address bit zero set.
// - Halfword loads report a bus error on failed memory access.
// - Linked loads set the link flag and perform a synchronisation.
// - Linked load waits for earlier accesses and holds later ones.
// - Word linked load monitors the word and sign-extends it.
// - Doubleword linked load monitors the doubleword and loads 64 bits as is; the monitor shrinks to its low word once a load of another kind is accepted.
// - Any exception or cache miss after a linked load clears the link flag.
// - Linked loads run in user mode without the control coprocessor.
// - Word linked load faults when either low two address bits is set.
// - Doubleword linked load faults when any low three address bits is set.
`include "plalu_defines.svh"
module plalu_load_unit
	import plalu_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Issue side
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire plalu_req_t  req,
	// Endian controls
	input  wire logic        memory_big_endian_flag,
	input  wire logic        processor_big_endian_flag,
	input  wire logic        user_endian_swap_flag,
	// Ordering and monitoring
	input  wire logic        older_accesses_done,
	input  wire logic        exception_taken,
	input  wire logic        cache_miss,
	input  wire logic        snoop_write,
	input  wire logic [63:0] snoop_addr,
	// Memory side
	output logic             mem_valid,
	output plalu_mem_t       mem_req,
	input  wire logic        mem_done,
	input  wire logic        mem_bus_error,
	input  wire logic [63:0] mem_data,
	// Results
	output logic             wb_valid,
	output plalu_wb_t        wb,
	output logic             addr_error,
	output logic             bus_error,
	output logic             hold_younger,
	output logic             link_flag,
	output logic [63:0]      link_addr
);

	typedef enum { ST_IDLE, ST_DRAIN, ST_MEM, ST_DONE } plalu_state_t;

	// Byte lane from low address bits and endian flag
	function automatic logic [2:0] lane_of(input logic [63:0] a, input logic [2:0] m);
		lane_of = a[2:0] ^ ({3{processor_big_endian_flag}} & m);
	endfunction

	plalu_state_t state, next_state;
	plalu_req_t   cur, next_cur;
	logic [63:0]  vaddr, next_vaddr;
	logic         next_wb_valid, next_addr_error, next_bus_error;
	plalu_wb_t    next_wb;
	logic         next_link_flag;
	logic [63:0]  next_link_addr;
	logic [63:0]  issue_vaddr;
	logic [63:0]  fwd_old;
	logic         misaligned;
	logic [2:0]   lane;
	logic [63:0]  shifted;
	logic [63:0]  merged;
	logic [63:0]  keep_mask;
	logic         link_op;
	logic [63:0]  link_span;

	////////////////////////////////////////////////////////////////////////////
	// Address formation and forwarding
	assign issue_vaddr = {{48{req.disp[`PLALU_DISP_MSB]}}, req.disp} + req.base;
	// Previous load result bypassed to a following partial load
	assign fwd_old = (wb_valid && wb.target == req.target) ? wb.data : req.target_old;
	// Also ready in the write-back cycle, so a following load meets the bypass
	assign req_ready = (state == ST_IDLE) || (state == ST_DONE);

	// Alignment check per kind
	always_comb
	begin
		unique case (req.op)
			PLALU_OP_HALF_S, PLALU_OP_HALF_U: misaligned = issue_vaddr[0];
			PLALU_OP_LINK_W:                  misaligned = |issue_vaddr[1:0];
			PLALU_OP_LINK_D:                  misaligned = |issue_vaddr[2:0];
			default:                          misaligned = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory request: lane, physical address and access type
	always_comb
	begin
		mem_req.vaddr = vaddr;
		mem_req.paddr = vaddr;
		mem_req.access_type = `PLALU_TYPE_DBL;
		lane = lane_of(vaddr, 3'h7);
		unique case (cur.op)
			PLALU_OP_RIGHT:
			begin
				mem_req.paddr[2:0] = memory_big_endian_flag ? `PLALU_ZERO3
					: (vaddr[2:0] ^ {3{user_endian_swap_flag}});
				mem_req.access_type = ~lane;
			end
			PLALU_OP_LEFT:
			begin
				mem_req.paddr[2:0] = memory_big_endian_flag ? (vaddr[2:0] ^ {3{user_endian_swap_flag}})
					: `PLALU_ZERO3;
				mem_req.access_type = lane;
			end
			PLALU_OP_HALF_S, PLALU_OP_HALF_U:
			begin
				lane = lane_of(vaddr, 3'h6);
				mem_req.paddr[2:0] = vaddr[2:0] ^ {user_endian_swap_flag, user_endian_swap_flag, 1'b0};
				mem_req.access_type = `PLALU_TYPE_HALF;
			end
			PLALU_OP_LINK_W:
			begin
				lane = lane_of(vaddr, 3'h4);
				mem_req.paddr[2:0] = vaddr[2:0] ^ {user_endian_swap_flag, 2'b00};
				mem_req.access_type = `PLALU_TYPE_WORD;
			end
			default:
			begin
				lane = `PLALU_ZERO3;
			end
		endcase
	end
	assign mem_valid = (state == ST_MEM);
	// Younger shared accesses wait behind a linked load
	assign link_op = (cur.op == PLALU_OP_LINK_W) || (cur.op == PLALU_OP_LINK_D);
	assign hold_younger = (state != ST_IDLE) && link_op;

	////////////////////////////////////////////////////////////////////////////
	// Data alignment, merge and extension
	assign shifted = mem_data >> {lane, 3'b000};
	assign keep_mask = ~(`PLALU_ZERO64 - 64'h1 >> {lane, 3'b000});
	always_comb
	begin
		unique case (cur.op)
			PLALU_OP_RIGHT:  merged = (cur.target_old & keep_mask) | shifted;
			PLALU_OP_LEFT:   merged = (mem_data << {~lane, 3'b000})
				| (cur.target_old & ~(64'hFFFFFFFFFFFFFFFF << {~lane, 3'b000}));
			PLALU_OP_HALF_S: merged = {{48{shifted[15]}}, shifted[15:0]};
			PLALU_OP_HALF_U: merged = {48'h000000000000, shifted[15:0]};
			PLALU_OP_LINK_W: merged = {{32{shifted[31]}}, shifted[31:0]};
			default:         merged = mem_data;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer next state; no privilege check on linked loads
	always_comb
	begin
		next_state = state;
		next_cur = cur;
		next_vaddr = vaddr;
		next_wb_valid = 1'b0;
		next_wb = wb;
		next_addr_error = 1'b0;
		next_bus_error = 1'b0;
		unique case (state)
			ST_IDLE, ST_DONE:
			begin
				next_state = ST_IDLE;
				if (req_valid && req.op != PLALU_OP_NONE)
				begin
					next_cur = req;
					next_cur.target_old = fwd_old;
					next_vaddr = issue_vaddr;
					if (misaligned)
						next_addr_error = 1'b1;
					else if (req.op == PLALU_OP_LINK_W || req.op == PLALU_OP_LINK_D)
						next_state = ST_DRAIN;
					else
						next_state = ST_MEM;
				end
			end
			ST_DRAIN:
			begin
				if (older_accesses_done)
					next_state = ST_MEM;
			end
			ST_MEM:
			begin
				if (mem_done)
				begin
					next_state = ST_DONE;
					if (mem_bus_error)
						next_bus_error = 1'b1;
					else
					begin
						next_wb_valid = 1'b1;
						next_wb.target = cur.target;
						next_wb.data = merged;
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Link flag and monitored address next values
	assign link_span = (cur.op == PLALU_OP_LINK_D) ? 64'hFFFFFFFFFFFFFFF8 : 64'hFFFFFFFFFFFFFFFC;
	always_comb
	begin
		next_link_flag = link_flag;
		next_link_addr = link_addr;
		if (exception_taken || cache_miss || addr_error || bus_error)
			next_link_flag = 1'b0;
		if (snoop_write && ((snoop_addr ^ link_addr) & link_span) == `PLALU_ZERO64)
			next_link_flag = 1'b0;
		if (state == ST_MEM && mem_done && !mem_bus_error && link_op)
		begin
			next_link_flag = 1'b1;
			next_link_addr = vaddr & link_span;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= ST_IDLE;
			cur <= '0;
			vaddr <= `PLALU_ZERO64;
			wb_valid <= 1'b0;
			wb <= '0;
			addr_error <= 1'b0;
			bus_error <= 1'b0;
			link_flag <= 1'b0;
			link_addr <= `PLALU_ZERO64;
		end
		else
		begin
			state <= next_state;
			cur <= next_cur;
			vaddr <= next_vaddr;
			wb_valid <= next_wb_valid;
			wb <= next_wb;
			addr_error <= next_addr_error;
			bus_error <= next_bus_error;
			link_flag <= next_link_flag;
			link_addr <= next_link_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_right_no_fault: assert property (@(posedge clk) disable iff (!rstn)
		(req_valid && req_ready && req.op == PLALU_OP_RIGHT) |=> !addr_error)
		else $error("right partial load raised alignment fault");
	a_half_odd_fault: assert property (@(posedge clk) disable iff (!rstn)
		(req_valid && req_ready && (req.op == PLALU_OP_HALF_S || req.op == PLALU_OP_HALF_U)
		&& issue_vaddr[0]) |=> addr_error && state == ST_IDLE)
		else $error("odd halfword load not faulted");
	a_word_link_fault: assert property (@(posedge clk) disable iff (!rstn)
		(req_valid && req_ready && req.op == PLALU_OP_LINK_W && |issue_vaddr[1:0]) |=> addr_error)
		else $error("misaligned word linked load not faulted");
	a_dbl_link_fault: assert property (@(posedge clk) disable iff (!rstn)
		(req_valid && req_ready && req.op == PLALU_OP_LINK_D && |issue_vaddr[2:0]) |=> addr_error)
		else $error("misaligned doubleword linked load not faulted");
	a_right_big_paddr: assert property (@(posedge clk) disable iff (!rstn)
		(mem_valid && cur.op == PLALU_OP_RIGHT && memory_big_endian_flag) |-> mem_req.paddr[2:0] == 3'h0)
		else $error("big-endian right load low address not zero");
	a_link_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
		(mem_valid && mem_done && !mem_bus_error && link_op) |=> link_flag && wb_valid)
		else $error("linked load did not set link flag");
	a_link_waits_drain: assert property (@(posedge clk) disable iff (!rstn)
		(state == ST_DRAIN && !older_accesses_done) |=> !mem_valid)
		else $error("linked load issued before older accesses drained");
	a_exc_clears_link: assert property (@(posedge clk) disable iff (!rstn)
		(exception_taken && !(mem_valid && mem_done)) |=> !link_flag)
		else $error("exception left link flag set");
	a_half_sign_ext: assert property (@(posedge clk) disable iff (!rstn)
		(wb_valid && cur.op == PLALU_OP_HALF_S) |-> wb.data[63:16] == {48{wb.data[15]}})
		else $error("signed halfword not sign-extended");
	a_half_zero_ext: assert property (@(posedge clk) disable iff (!rstn)
		(wb_valid && cur.op == PLALU_OP_HALF_U) |-> wb.data[63:16] == 48'h000000000000)
		else $error("unsigned halfword not zero-extended");
	a_bus_err_half: assert property (@(posedge clk) disable iff (!rstn)
		(mem_valid && mem_done && mem_bus_error) |=> bus_error && !wb_valid)
		else $error("bus error not reported");

	c_right_load: cover property (@(posedge clk) disable iff (!rstn) wb_valid && cur.op == PLALU_OP_RIGHT);
	c_link_done:  cover property (@(posedge clk) disable iff (!rstn) $rose(link_flag));
	c_addr_fault: cover property (@(posedge clk) disable iff (!rstn) addr_error);
	c_snoop_kill: cover property (@(posedge clk) disable iff (!rstn) $fell(link_flag) && $past(snoop_write));

endmodule // plalu_load_unit

/* plalu_mem_model.sv */
/*
 * Behavioural cache and memory partner for the load unit bench.
 * Assumes plalu_pkg is compiled first and one request is open at a time.
 */
module plalu_mem_model
	import plalu_pkg::*;
#(
	parameter logic [63:0] PATTERN = 64'hF1E2D3C4B5A69788
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Scenario controls
	input  wire logic [3:0]  delay,
	input  wire logic        fail,
	// Memory side
	input  wire logic        mem_valid,
	input  wire plalu_mem_t  mem_req,
	output logic             mem_done,
	output logic             mem_bus_error,
	output logic [63:0]      mem_data
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0]  wait_cnt;
	logic [63:0] last;

	////////////////////////////////////////////////////////////////////////
	// One answer per request, after the commanded wait
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wait_cnt      <= 4'h0;
			mem_done      <= 1'b0;
			mem_bus_error <= 1'b0;
			last          <= 64'h0;
		end
		else if (mem_done || !mem_valid)
		begin
			wait_cnt      <= 4'h0;
			mem_done      <= 1'b0;
			mem_bus_error <= 1'b0;
		end
		else if (wait_cnt >= delay)
		begin
			mem_done      <= 1'b1;
			mem_bus_error <= fail;
			last          <= PATTERN ^ {mem_req.paddr[63:3], 3'h0}; // Whole aligned doubleword
		end
		else
			wait_cnt <= wait_cnt + 4'h1;
	end

	// Data lines carry garbage outside the answer cycle
	assign mem_data = mem_done ? last : ~last;
endmodule // plalu_mem_model

/* plalu_load_unit_test.sv */
/*
 * Self-checking bench for the partial and linked load unit.
 * Assumes plalu_pkg and plalu_mem_model are compiled first.
 */
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", name, exp, got); end end

module plalu_load_unit_test;
	import plalu_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [63:0] PAT = 64'hF1E2D3C4B5A69788;
	localparam logic [63:0] OLD = 64'h0123456789ABCDEF;

	typedef struct packed
	{
		plalu_op_t   op;
		logic [15:0] disp;
		logic [63:0] base;
		logic        becpu;
		logic        bem;
		logic [1:0]  kind;
		logic [3:0]  dly;
		logic        fail;
	} plalu_row_t;

	logic        clk, rstn, req_valid, req_ready, mem_valid, mem_done, mem_bus_error, wb_valid;
	logic        memory_big_endian_flag, processor_big_endian_flag, user_endian_swap_flag;
	logic        older_accesses_done, exception_taken, cache_miss, snoop_write;
	logic        addr_error, bus_error, hold_younger, link_flag, fail;
	logic [63:0] snoop_addr, mem_data, link_addr, va, data;
	logic [3:0]  dly;
	logic [1:0]  kind;
	plalu_req_t  req;
	plalu_mem_t  mem_req, mr;
	plalu_wb_t   wb;
	plalu_row_t  r;
	int          failures, checked;

	// Kind: 0 write-back, 1 alignment fault, 2 bus fault
	plalu_row_t rows [14] = '{
		'{PLALU_OP_RIGHT,  16'h0000, 64'h1000, '0, '0, 2'h0, 4'h0, '0},
		'{PLALU_OP_RIGHT,  16'hFFFE, 64'h2005, '0, '0, 2'h0, 4'h2, '0},
		'{PLALU_OP_RIGHT,  16'h0007, 64'h3000, '0, '1, 2'h0, 4'h0, '0},
		'{PLALU_OP_RIGHT,  16'h0002, 64'h4000, '1, '1, 2'h0, 4'h1, '0},
		'{PLALU_OP_HALF_S, 16'h0006, 64'h5000, '0, '0, 2'h0, 4'h0, '0},
		'{PLALU_OP_HALF_U, 16'h0002, 64'h5000, '1, '1, 2'h0, 4'h3, '0},
		'{PLALU_OP_HALF_S, 16'h0001, 64'h5000, '0, '0, 2'h1, 4'h0, '0},
		'{PLALU_OP_HALF_U, 16'hFFFF, 64'h5000, '0, '0, 2'h1, 4'h0, '0},
		'{PLALU_OP_HALF_S, 16'h0000, 64'h6000, '0, '0, 2'h2, 4'h1, '1},
		'{PLALU_OP_LINK_W, 16'h0004, 64'h7000, '0, '0, 2'h0, 4'h0, '0},
		'{PLALU_OP_LINK_W, 16'h0000, 64'h7000, '1, '1, 2'h0, 4'h1, '0},
		'{PLALU_OP_LINK_D, 16'h0008, 64'h7000, '0, '0, 2'h0, 4'h0, '0},
		'{PLALU_OP_LINK_W, 16'h0002, 64'h7000, '0, '0, 2'h1, 4'h0, '0},
		'{PLALU_OP_LINK_D, 16'h0004, 64'h7000, '0, '0, 2'h1, 4'h0, '0}};

	////////////////////////////////////////////////////////////////////////
	// Unit under test and memory partner
	plalu_load_unit i_plalu_load_unit (.clk, .rstn, .req_valid, .req_ready, .req,
		.memory_big_endian_flag, .processor_big_endian_flag, .user_endian_swap_flag,
		.older_accesses_done, .exception_taken, .cache_miss, .snoop_write, .snoop_addr,
		.mem_valid, .mem_req, .mem_done, .mem_bus_error, .mem_data, .wb_valid, .wb,
		.addr_error, .bus_error, .hold_younger, .link_flag, .link_addr);

	plalu_mem_model #(.PATTERN(PAT)) i_plalu_mem_model (.clk, .rstn, .delay(dly), .fail,
		.mem_valid, .mem_req, .mem_done, .mem_bus_error, .mem_data);

	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Expected load result from lane, extension and merge
	function automatic logic [63:0] expect_data(plalu_op_t op, logic [63:0] a, logic be);
		logic [63:0] m, hs, ws;
		logic [2:0]  ln;
		m  = PAT ^ {a[63:3], 3'h0};
		ln = a[2:0] ^ {3{be}};
		hs = m >> (8 * (a[2:0] ^ {be, be, 1'b0}));
		ws = m >> (8 * (a[2:0] ^ {be, 2'h0}));
		case (op)
			PLALU_OP_RIGHT:  return (m >> (8 * ln)) | (OLD & ~(~64'h0 >> (8 * ln)));
			PLALU_OP_HALF_S: return {{48{hs[15]}}, hs[15:0]};
			PLALU_OP_HALF_U: return {48'h0, hs[15:0]};
			PLALU_OP_LINK_W: return {{32{ws[31]}}, ws[31:0]};
			default:         return m;
		endcase
	endfunction

	// Verdict and end of run
	task automatic results();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Present one load and hold it until the unit takes it
	task automatic issue(input plalu_op_t op, input logic [15:0] disp, input logic [63:0] base, old);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req       <= '{op, 5'h3, disp, base, old};
		@(negedge clk);
		while (!req_ready && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		if (n >= 50)
		begin
			failures++;
			results();
		end
	endtask

	// Issue one load and collect its outcome and memory request
	task automatic run(input plalu_op_t op, input logic [15:0] disp, input logic [63:0] base, old);
		issue(op, disp, base, old);
		collect();
	endtask

	// Wait for the outcome of the load in flight
	task automatic collect();
		int n;
		n    = 0;
		kind = 2'h3;
		mr   = '0;
		while (kind == 2'h3 && n < 50)
		begin
			@(negedge clk);
			n++;
			if (mem_valid)
				mr = mem_req;
			if (bus_error)
				kind = 2'h2;
			else if (addr_error)
				kind = 2'h1;
			else if (wb_valid)
			begin
				kind = 2'h0;
				data = wb.data;
			end
		end
		if (n >= 50)
		begin
			failures++;
			results();
		end
		@(negedge clk);
	endtask

	// Pulse a snoop (0), exception (1) or cache miss (2)
	task automatic hit(input int which, input logic [63:0] a);
		@(posedge clk);
		snoop_addr      <= a;
		snoop_write     <= (which == 0);
		exception_taken <= (which == 1);
		cache_miss      <= (which == 2);
		@(posedge clk);
		{snoop_write, exception_taken, cache_miss} <= 3'h0;
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{rstn, req_valid, memory_big_endian_flag, processor_big_endian_flag} = 4'h0;
		{user_endian_swap_flag, exception_taken, cache_miss, snoop_write, fail} = 5'h0;
		{req, snoop_addr, dly, failures, checked} = '0;
		older_accesses_done = 1'b1;
		repeat (5) @(posedge clk);
		`CHK("ready in reset", 1'b1, req_ready)
		`CHK("link in reset", 1'b0, link_flag)
		rstn <= 1'b1;
		foreach (rows[i])
		begin
			r = rows[i];
			@(posedge clk);
			{processor_big_endian_flag, memory_big_endian_flag, dly, fail} <= {r.becpu, r.bem, r.dly, r.fail};
			va = r.base + {{48{r.disp[15]}}, r.disp};
			run(r.op, r.disp, r.base, OLD);
			`CHK("kind", r.kind, kind)
			`CHK("vaddr", (kind == 2'h1) ? 64'h0 : va, mr.vaddr)
			if (kind == 2'h0)
			begin
				`CHK("data", expect_data(r.op, va, r.becpu), data)
				`CHK("target", 5'h3, wb.target)
			end
			if (r.op == PLALU_OP_RIGHT)
			begin
				`CHK("low paddr", r.bem ? 3'h0 : va[2:0], mr.paddr[2:0])
				`CHK("type", 3'h7 - (va[2:0] ^ {3{r.becpu}}), mr.access_type)
			end
			if (r.op >= PLALU_OP_LINK_W || kind != 2'h0)
				`CHK("link", kind == 2'h0, link_flag)
		end
		// Linked load waits for older accesses, then watches its doubleword
		@(posedge clk);
		{processor_big_endian_flag, memory_big_endian_flag, dly, fail, older_accesses_done} <= '0;
		fork
			run(PLALU_OP_LINK_D, 16'h0000, 64'h9000, OLD);
			begin
				repeat (6) @(negedge clk);
				`CHK("held", 2'b01, {mem_valid, hold_younger})
				@(posedge clk);
				older_accesses_done <= 1'b1;
			end
		join
		`CHK("link addr", 64'h9000, link_addr)
		hit(0, 64'h9008);
		`CHK("other dword", 1'b1, link_flag)
		hit(0, 64'h9004);
		`CHK("dword write", 1'b0, link_flag)
		// Word monitor granularity
		run(PLALU_OP_LINK_W, 16'h0004, 64'hA000, OLD);
		hit(0, 64'hA000);
		`CHK("other word", 1'b1, link_flag)
		hit(0, 64'hA006);
		`CHK("word write", 1'b0, link_flag)
		// Exception and cache miss break the link
		for (int w = 1; w < 3; w++)
		begin
			run(PLALU_OP_LINK_W, 16'h0000, 64'hA000, OLD);
			hit(w, 64'h0);
			`CHK("link broken", 1'b0, link_flag)
		end
		// Left then right part back to back; the right part gets the left result by bypass
		fork
			run(PLALU_OP_LEFT, 16'h000A, 64'hB000, OLD);
			begin
				repeat (2) @(posedge clk);
				issue(PLALU_OP_RIGHT, 16'h0003, 64'hB000, OLD);
			end
		join
		collect();
		`CHK("pair", ((PAT ^ 64'hB008) << 40) | ((PAT ^ 64'hB000) >> 24), data)
		// Swapped user endianness still gives a zero low address on big-endian memory
		@(posedge clk);
		{user_endian_swap_flag, memory_big_endian_flag} <= 2'h3;
		run(PLALU_OP_RIGHT, 16'h0005, 64'hD000, OLD);
		`CHK("swap paddr", 3'h0, mr.paddr[2:0])
		`CHK("swap data", expect_data(PLALU_OP_RIGHT, 64'hD005, 1'b0), data)
		// Reset in mid-run clears the link
		run(PLALU_OP_LINK_D, 16'h0000, 64'hC000, OLD);
		`CHK("link before reset", 1'b1, link_flag)
		@(posedge clk);
		rstn <= 1'b0;
		@(negedge clk);
		`CHK("link after reset", 1'b0, link_flag)
		`CHK("ready after reset", 1'b1, req_ready)
		results();
	end
endmodule // plalu_load_unit_test
